// ===== logic/dmr_mode_regs.sv
// Purpose: memory-side decode of mode-set commands and field outputs
// Assumes: command pins are synchronous to mem_clk_i, the link clock
// Notes: registers live in the link domain; fields cross to clock_i
`timescale 1ns/1ps
module dmr_mode_regs
  import dmr_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = DMR_LOCK_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic mem_clk_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] bank_i,
  input wire logic [13:0] addr_i,
  input wire logic self_refresh_i,
  output logic [2:0] burst_length_o,
  output logic burst_interleave_o,
  output logic [2:0] read_latency_o,
  output logic read_latency_ok_o,
  output logic test_mode_o,
  output logic [2:0] write_recovery_o,
  output logic loop_enabled_o,
  output logic loop_locked_o,
  output logic reduced_drive_o,
  output logic [1:0] termination_o,
  output logic [2:0] additive_latency_o,
  output logic [2:0] driver_impedance_calibration_o,
  output logic strobe_n_disable_o,
  output logic read_strobe_en_o,
  output logic write_mask_en_o
);
  // ---------------------------------------------------------------
  // link-domain reset and command decode
  // ---------------------------------------------------------------
  logic lrst_meta_ff;
  logic lrst_ff;
  always_ff @(posedge mem_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lrst_meta_ff <= 1'b1;
      lrst_ff <= 1'b1;
    end else begin
      lrst_meta_ff <= 1'b0;
      lrst_ff <= lrst_meta_ff;
    end
  end

  // the self refresh level comes from outside the link domain
  logic sr_meta_ff;
  logic sr_pin_ff;
  always_ff @(posedge mem_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sr_meta_ff <= 1'b0;
      sr_pin_ff <= 1'b0;
    end else begin
      sr_meta_ff <= self_refresh_i;
      sr_pin_ff <= sr_meta_ff;
    end
  end

  logic cmd_mode_set;
  logic cmd_sr_entry;
  logic cke_prev_ff;
  // a high chip select masks both decoded commands, not the cke-driven self refresh exit, so decode starts from it
  assign cmd_mode_set = cke_i && !cs_n_i && {ras_n_i, cas_n_i, we_n_i} == DMR_CMD_MODE_SET;
  assign cmd_sr_entry = cke_prev_ff && !cke_i && !cs_n_i
                        && {ras_n_i, cas_n_i, we_n_i} == DMR_CMD_REFRESH;

  logic [13:0] mode_register_ff;
  logic [13:0] extended_mode_register_one_ff;
  logic self_refresh_ff;
  logic loop_reset_req;

  always_ff @(posedge mem_clk_i or posedge lrst_ff) begin
    if (lrst_ff) begin
      cke_prev_ff <= 1'b0;
    end else begin
      cke_prev_ff <= cke_i;
    end
  end

  // writes only touch these registers, never the array
  always_ff @(posedge mem_clk_i or posedge lrst_ff) begin
    if (lrst_ff) begin
      mode_register_ff <= DMR_REG_RST;
    end else if (cmd_mode_set && bank_i == DMR_BANK_MODE) begin
      mode_register_ff <= addr_i;
    end
  end

  always_ff @(posedge mem_clk_i or posedge lrst_ff) begin
    if (lrst_ff) begin
      extended_mode_register_one_ff <= DMR_REG_RST;
    end else if (cmd_mode_set && bank_i == DMR_BANK_EXT1) begin
      extended_mode_register_one_ff <= addr_i;
    end
  end

  // self refresh exits on cke high once the pin is low; entry is refresh with cke falling, or the self refresh pin
  always_ff @(posedge mem_clk_i or posedge lrst_ff) begin
    if (lrst_ff) begin
      self_refresh_ff <= 1'b0;
    end else if (cmd_sr_entry || sr_pin_ff) begin
      self_refresh_ff <= 1'b1;
    end else if (cke_i) begin
      self_refresh_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // clock alignment loop lock counter
  // ---------------------------------------------------------------
  logic loop_on;
  logic [8:0] lock_cnt_ff;
  assign loop_on = !extended_mode_register_one_ff[DMR_E1_DLLDIS_BIT] && !self_refresh_ff;
  assign loop_reset_req = (cmd_mode_set && bank_i == DMR_BANK_MODE && addr_i[DMR_MR_DLLRST_BIT])
                          || (cmd_mode_set && bank_i == DMR_BANK_EXT1 && !addr_i[DMR_E1_DLLDIS_BIT]
                              && extended_mode_register_one_ff[DMR_E1_DLLDIS_BIT])
                          || (self_refresh_ff && cke_i);

  always_ff @(posedge mem_clk_i or posedge lrst_ff) begin
    if (lrst_ff) begin
      lock_cnt_ff <= 9'h000;
    end else if (!loop_on || loop_reset_req) begin
      lock_cnt_ff <= 9'h000;
    end else if (lock_cnt_ff < 9'(LOCK_CYCLES)) begin
      lock_cnt_ff <= lock_cnt_ff + 9'h001;
    end
  end

  logic locked_l;
  assign locked_l = loop_on && lock_cnt_ff >= 9'(LOCK_CYCLES);

  // ---------------------------------------------------------------
  // crossing to clock_i: quasi-static register levels
  // ---------------------------------------------------------------
  // fields change only on mode writes spaced by the mode-write cycle time,
  // so per-bit synchronisers settle before anyone uses them
  logic [29:0] link_bus;
  logic [29:0] sys_bus;
  assign link_bus = {locked_l, loop_on, extended_mode_register_one_ff, mode_register_ff};

  dmr_sync #(.WIDTH(30)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .data_i(link_bus),
    .data_o(sys_bus)
  );

  // bits of one word may land a cycle apart; take the word once it reads the same twice
  logic [29:0] sys_prev_ff;
  logic [29:0] sys_word_ff;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sys_prev_ff <= 30'h00000000;
      sys_word_ff <= 30'h00000000;
    end else begin
      sys_prev_ff <= sys_bus;
      if (sys_bus == sys_prev_ff) begin
        sys_word_ff <= sys_bus;
      end
    end
  end

  logic [13:0] mr_s;
  logic [13:0] e1_s;
  assign mr_s = sys_word_ff[13:0];
  assign e1_s = sys_word_ff[27:14];

  // ---------------------------------------------------------------
  // field decode, registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      burst_length_o <= 3'h0;
      burst_interleave_o <= 1'b0;
      read_latency_o <= 3'h0;
      read_latency_ok_o <= 1'b0;
      test_mode_o <= 1'b0;
      write_recovery_o <= 3'h0;
    end else begin
      burst_length_o <= mr_s[DMR_MR_BL_LSB +: 3];
      burst_interleave_o <= mr_s[DMR_MR_BT_BIT];
      read_latency_o <= mr_s[DMR_MR_CL_LSB +: 3];
      // whole-clock latencies only
      read_latency_ok_o <= mr_s[DMR_MR_CL_LSB +: 3] >= DMR_CL_MIN
                           && mr_s[DMR_MR_CL_LSB +: 3] <= DMR_CL_MAX
                           && (mr_s[DMR_MR_BL_LSB +: 3] == DMR_BL_4
                               || mr_s[DMR_MR_BL_LSB +: 3] == DMR_BL_8);
      test_mode_o <= mr_s[DMR_MR_TM_BIT];
      write_recovery_o <= mr_s[DMR_MR_WR_LSB +: 3];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      loop_enabled_o <= 1'b0;
      loop_locked_o <= 1'b0;
      reduced_drive_o <= 1'b0;
      termination_o <= 2'h0;
      additive_latency_o <= 3'h0;
      driver_impedance_calibration_o <= 3'h0;
      strobe_n_disable_o <= 1'b0;
      read_strobe_en_o <= 1'b0;
      write_mask_en_o <= 1'b1;
    end else begin
      loop_enabled_o <= sys_word_ff[28];
      loop_locked_o <= sys_word_ff[29];
      reduced_drive_o <= e1_s[DMR_E1_RDS_BIT];
      termination_o <= {e1_s[DMR_E1_RTT1_BIT], e1_s[DMR_E1_RTT0_BIT]};
      additive_latency_o <= e1_s[DMR_E1_AL_LSB +: 3];
      driver_impedance_calibration_o <= e1_s[DMR_E1_OCD_LSB +: 3];
      strobe_n_disable_o <= e1_s[DMR_E1_DQSDIS_BIT];
      read_strobe_en_o <= e1_s[DMR_E1_RDQS_BIT];
      write_mask_en_o <= !e1_s[DMR_E1_RDQS_BIT];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_mode_load: assert property (@(posedge mem_clk_i) disable iff (lrst_ff)
    cmd_mode_set && bank_i == DMR_BANK_MODE |=> mode_register_ff == $past(addr_i))
    else $error("mode register did not load");
  a_ext_load: assert property (@(posedge mem_clk_i) disable iff (lrst_ff)
    cmd_mode_set && bank_i == DMR_BANK_EXT1 |=> extended_mode_register_one_ff == $past(addr_i))
    else $error("register one did not load");
  a_cs_masks: assert property (@(posedge mem_clk_i) disable iff (lrst_ff)
    cs_n_i |=> $stable(mode_register_ff) && $stable(extended_mode_register_one_ff))
    else $error("masked command changed a register");
  a_other_bank: assert property (@(posedge mem_clk_i) disable iff (lrst_ff)
    cmd_mode_set && bank_i[2:1] != 2'h0 |=> $stable(mode_register_ff))
    else $error("other bank write changed mode register");
  a_lock_wait: assert property (@(posedge mem_clk_i) disable iff (lrst_ff)
    loop_reset_req |=> !locked_l [*8])
    else $error("lock reported too soon after reset");
  a_sr_off: assert property (@(posedge mem_clk_i) disable iff (lrst_ff)
    cmd_sr_entry |=> !loop_on)
    else $error("loop still on in self refresh");
  sequence s_strobe_set;
    e1_s[DMR_E1_RDQS_BIT] ##1 e1_s[DMR_E1_RDQS_BIT];
  endsequence
  a_mask_off: assert property (@(posedge clock_i) disable iff (rst_i)
    s_strobe_set |-> read_strobe_en_o && !write_mask_en_o)
    else $error("write mask active with read strobe");
  a_latency_ok: assert property (@(posedge clock_i) disable iff (rst_i)
    read_latency_ok_o |-> read_latency_o >= DMR_CL_MIN && read_latency_o <= DMR_CL_MAX)
    else $error("latency flagged valid out of range");
endmodule : dmr_mode_regs

// ===== logic/dmr_pkg.sv
// Purpose: constants for the memory-side mode register block
// Assumes: command pins sampled on the memory clock (link domain)
// Notes: field positions follow the register layouts below
package dmr_pkg;
  localparam int unsigned DMR_ADDR_W = 14;
  localparam int unsigned DMR_BANK_W = 3;
  localparam logic [2:0] DMR_BANK_MODE = 3'h0;
  localparam logic [2:0] DMR_BANK_EXT1 = 3'h1;
  localparam logic [2:0] DMR_BANK_EXT2 = 3'h2;
  localparam logic [2:0] DMR_BANK_EXT3 = 3'h3;
  // command code {ras_n, cas_n, we_n}
  localparam logic [2:0] DMR_CMD_MODE_SET = 3'h0;
  localparam logic [2:0] DMR_CMD_REFRESH = 3'h1;
  // mode register fields
  localparam int unsigned DMR_MR_BL_LSB = 0;
  localparam int unsigned DMR_MR_BT_BIT = 3;
  localparam int unsigned DMR_MR_CL_LSB = 4;
  localparam int unsigned DMR_MR_TM_BIT = 7;
  localparam int unsigned DMR_MR_DLLRST_BIT = 8;
  localparam int unsigned DMR_MR_WR_LSB = 9;
  localparam logic [2:0] DMR_BL_4 = 3'h2;
  localparam logic [2:0] DMR_BL_8 = 3'h3;
  localparam logic [2:0] DMR_CL_MIN = 3'h3;
  localparam logic [2:0] DMR_CL_MAX = 3'h6;
  // register one fields
  localparam int unsigned DMR_E1_DLLDIS_BIT = 0;
  localparam int unsigned DMR_E1_RDS_BIT = 1;
  localparam int unsigned DMR_E1_RTT0_BIT = 2;
  localparam int unsigned DMR_E1_AL_LSB = 3;
  localparam int unsigned DMR_E1_RTT1_BIT = 6;
  localparam int unsigned DMR_E1_OCD_LSB = 7;
  localparam int unsigned DMR_E1_DQSDIS_BIT = 10;
  localparam int unsigned DMR_E1_RDQS_BIT = 11;
  localparam logic [2:0] DMR_OCD_EXIT = 3'h0;
  localparam logic [2:0] DMR_OCD_DEFAULT = 3'h7;
  localparam int unsigned DMR_LOCK_CYCLES = 200;
  localparam logic [13:0] DMR_REG_RST = 14'h0000;
endpackage : dmr_pkg

// ===== logic/dmr_sync.sv
// Purpose: two-stage level synchroniser, one per bit
// Assumes: input is a level that holds for several destination clocks
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module dmr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] data_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= data_i[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign data_o = sync_ff;
endmodule : dmr_sync

// ===== sim/dmr_ctrl_model.sv
// Purpose: controller-side model driving the memory command pins
// Assumes: mem_clk_i runs free; pins change on its falling edge
// Notes: the clock-stable wait is cut short to keep runs brief
`timescale 1ns/1ps
module dmr_ctrl_model
  import dmr_pkg::*;
#(
  parameter int unsigned STABLE_CYC = 100
) (
  input wire logic mem_clk_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic [2:0] cmd_n_o,
  output logic [2:0] bank_o,
  output logic [13:0] addr_o
);
  initial begin
    cke_o = 1'b0;
    cs_n_o = 1'b1;
    cmd_n_o = 3'h7;
    bank_o = 3'h0;
    addr_o = 14'h0000;
  end
  // released command, bank and address lines show the inverse, chip select goes high, so stale values cannot pass
  task automatic cmd(input logic cs_n, input logic [2:0] code, input logic [2:0] bank, input logic [13:0] addr);
    @(negedge mem_clk_i);
    cs_n_o = cs_n;
    cmd_n_o = code;
    bank_o = bank;
    addr_o = addr;
    @(negedge mem_clk_i);
    cs_n_o = 1'b1;
    cmd_n_o = ~code;
    bank_o = ~bank;
    addr_o = ~addr;
    repeat (2) @(negedge mem_clk_i);
  endtask : cmd
  task automatic mset(input logic [2:0] bank, input logic [13:0] addr);
    cmd(1'b0, DMR_CMD_MODE_SET, bank, addr);
  endtask : mset
  task automatic init(input logic [13:0] mr, input logic [13:0] e1);
    repeat (STABLE_CYC) @(negedge mem_clk_i);
    cmd(1'b0, 3'h7, 3'h0, 14'h0000);
    cke_o = 1'b1;
    repeat (67) @(negedge mem_clk_i);
    cmd(1'b0, 3'h2, 3'h0, 14'h0400);
    mset(DMR_BANK_EXT2, 14'h0000);
    mset(DMR_BANK_EXT3, 14'h0000);
    mset(DMR_BANK_EXT1, e1 & 14'h1c7e);
    mset(DMR_BANK_MODE, (mr | 14'h0100) & 14'h1fff);
    cmd(1'b0, 3'h2, 3'h0, 14'h0400);
    repeat (2) cmd(1'b0, DMR_CMD_REFRESH, 3'h0, 14'h0000);
    mset(DMR_BANK_MODE, mr & 14'h1eff);
    repeat (200) @(negedge mem_clk_i);
    mset(DMR_BANK_EXT1, e1 | 14'h0380);
    mset(DMR_BANK_EXT1, e1 & 14'h1c7f);
  endtask : init
  task automatic self_refresh(input logic enter);
    @(negedge mem_clk_i);
    cs_n_o = ~enter;
    cmd_n_o = enter ? DMR_CMD_REFRESH : 3'h7;
    cke_o = ~enter;
    @(negedge mem_clk_i);
    cs_n_o = 1'b1;
  endtask : self_refresh
endmodule : dmr_ctrl_model

// ===== sim/tb_top.sv
// Purpose: self-checking bench for the mode register block
// Assumes: field outputs settle within 8 system clocks of a command
// Notes: lock count shortened to 20 link clocks
`timescale 1ns/1ps
module tb_top;
  import dmr_pkg::*;
  logic clock_i, rst_i, mem_clk, sr_pin, cke, cs_n;
  logic [2:0] cmd_n, bank, bl, rl, wr, al, driver_impedance_calibration;
  logic [13:0] addr;
  logic bi, rlok, tm, le, ll, rd, sd, rse, wme;
  logic [1:0] term;
  int err_total = 0;
  int samples_checked = 0;
  wire [13:0] mr_view = {2'h0, wr, 1'b0, tm, rl, bi, bl};
  wire [13:0] e1_view = {2'h0, rse, sd, driver_impedance_calibration, term[1], al, term[0], rd, ~le};
  dmr_ctrl_model m (.mem_clk_i(mem_clk), .cke_o(cke), .cs_n_o(cs_n), .cmd_n_o(cmd_n), .bank_o(bank),
    .addr_o(addr));
  dmr_mode_regs #(.LOCK_CYCLES(20)) uut (.clock_i(clock_i), .rst_i(rst_i), .mem_clk_i(mem_clk),
    .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]),
    .bank_i(bank), .addr_i(addr), .self_refresh_i(sr_pin), .burst_length_o(bl),
    .burst_interleave_o(bi), .read_latency_o(rl), .read_latency_ok_o(rlok), .test_mode_o(tm),
    .write_recovery_o(wr), .loop_enabled_o(le), .loop_locked_o(ll), .reduced_drive_o(rd),
    .termination_o(term), .additive_latency_o(al), .driver_impedance_calibration_o(driver_impedance_calibration),
    .strobe_n_disable_o(sd), .read_strobe_en_o(rse), .write_mask_en_o(wme));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // link clock offset so its edges never line up with the system clock
  initial begin
    mem_clk = 1'b0;
    #1.7;
    forever #3 mem_clk = ~mem_clk;
  end
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wait_clk
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic t_init();
    m.init(14'h0a33, 14'h0014);
    wait_clk(8);
    chk("mode fields", 14'h0a33, mr_view);
    chk("ext1 fields", 14'h0014, e1_view);
    chk("latency ok", 14'h0001, {13'h0, rlok});
    chk("locked", 14'h0001, {13'h0, ll});
  endtask : t_init
  task automatic t_lock();
    m.mset(DMR_BANK_MODE, 14'h0b33);
    wait_clk(6);
    chk("lock cleared", 14'h0000, {13'h0, ll});
    wait_clk(30);
    chk("relocked", 14'h0001, {13'h0, ll});
    chk("mode kept", 14'h0a33, mr_view);
  endtask : t_lock
  task automatic t_mask();
    m.cmd(1'b1, DMR_CMD_MODE_SET, DMR_BANK_MODE, 14'h0042);
    m.mset(DMR_BANK_EXT2, 14'h0fff);
    m.mset(DMR_BANK_EXT3, 14'h0fff);
    wait_clk(8);
    chk("masked mode", 14'h0a33, mr_view);
    chk("other banks", 14'h0014, e1_view);
  endtask : t_mask
  task automatic t_ext1();
    logic [13:0] v [3] = '{14'h0800, 14'h07ff, 14'h0014};
    for (int i = 0; i < 3; i++) begin
      m.mset(DMR_BANK_EXT1, v[i]);
      wait_clk(8);
      chk("ext1 word", v[i], e1_view);
      chk("write mask", {13'h0, ~v[i][11]}, {13'h0, wme});
    end
  endtask : t_ext1
  task automatic t_latency();
    logic [13:0] v [5] = '{14'h0023, 14'h0033, 14'h0062, 14'h0073, 14'h0031};
    logic ok [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      m.mset(DMR_BANK_MODE, v[i]);
      wait_clk(8);
      chk("mode word", v[i], mr_view);
      chk("latency ok", {13'h0, ok[i]}, {13'h0, rlok});
    end
  endtask : t_latency
  task automatic t_self_refresh();
    m.self_refresh(1'b1);
    wait_clk(8);
    chk("loop off", 14'h0000, {13'h0, le});
    m.self_refresh(1'b0);
    wait_clk(6);
    chk("loop back", 14'h0001, {13'h0, le});
    chk("loop reset", 14'h0000, {13'h0, ll});
    wait_clk(30);
    chk("loop locked", 14'h0001, {13'h0, ll});
    sr_pin = 1'b1;
    wait_clk(8);
    chk("pin loop off", 14'h0000, {13'h0, le});
    sr_pin = 1'b0;
  endtask : t_self_refresh
  initial begin
    rst_i = 1'b1;
    sr_pin = 1'b0;
    wait_clk(2);
    chk("mode in reset", 14'h0000, mr_view);
    chk("mask in reset", 14'h0001, {13'h0, wme});
    rst_i = 1'b0;
    t_init();
    t_lock();
    t_mask();
    t_ext1();
    t_latency();
    t_self_refresh();
    complete_run();
  end
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule : tb_top
